// ---- pkg/ldi_defs.svh ----
`ifndef LDI_DEFS_SVH
`define LDI_DEFS_SVH

// Register addresses on the register port
`define LDI_ADDR_STAT 8'h02
`define LDI_ADDR_EN 8'h03
`define LDI_ADDR_SEL_HI 8'h04
`define LDI_ADDR_SEL_LO 8'h05

// Implemented bits of each register; the rest read as zero
`define LDI_MASK_STAT 8'h7C
`define LDI_MASK_EN 8'h7C
`define LDI_MASK_SEL_HI 8'h01
`define LDI_MASK_SEL_LO 8'hFF

// Reset values
`define LDI_RST_STAT 8'h00
`define LDI_RST_EN 8'h00
`define LDI_RST_SEL_HI 8'h00
`define LDI_RST_SEL_LO 8'h00
`define LDI_RST_RDATA 8'h00
`define LDI_RST_CNT 13'h0000
`define LDI_RST_SINKS 9'h000

// Flag and enable bit positions (same in status and enable registers)
`define LDI_BIT_ISC 6
`define LDI_BIT_BL 5
`define LDI_BIT_SHORT 4
`define LDI_BIT_TSD 3
`define LDI_BIT_OVP 2

// Sink 9 membership bit in the high select register
`define LDI_BIT_SINK9 0

// Sink count and bus widths
`define LDI_SINKS 9
`define LDI_DW 8
`define LDI_CW 13

// Line drop time while other events stay pending
`define LDI_DROP_NS 50000
`define LDI_CLK_NS 10
`define LDI_DROP_CYCLES (`LDI_DROP_NS / `LDI_CLK_NS)

`endif

// ---- pkg/ldi_pkg.sv ----
`include "ldi_defs.svh"

package ldi_pkg;

    // Interrupt line behaviour
    typedef enum logic [0:0] {
        LINE_FOLLOW, // Line follows enabled pending flags
        LINE_DROP // Line released for the drop time
    } ldi_line_t;

    // Complete state of the interrupt controller
    typedef struct packed {
        logic [`LDI_DW-1:0] intStat; // Sticky event flags
        logic [`LDI_DW-1:0] intEn; // Interrupt enables
        logic [`LDI_DW-1:0] selHi; // Sink 9 membership
        logic [`LDI_DW-1:0] selLo; // Sinks 8..1 membership
        logic [`LDI_DW-1:0] rdData; // Registered read data
        ldi_line_t line; // Interrupt line mode
        logic [`LDI_CW-1:0] dropCnt; // Cycles left in the drop
        logic intN; // Registered interrupt line, low active
    } ldi_state_t;

    // State of the sink group monitor
    typedef struct packed {
        logic [`LDI_SINKS-1:0] prevOn; // Sink on status one cycle ago
    } ldi_mon_state_t;

endpackage

// ---- rtl/ldi_sink_group_mon.sv ----
`timescale 1ns/1ps
`include "ldi_defs.svh"

module ldi_sink_group_mon (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [`LDI_SINKS-1:0] sinkOn, // Sink is on, bit 0 is sink 1
    input wire logic [`LDI_SINKS-1:0] groupSel, // Sink is a group member
    output logic groupOff // Pulse: last on member of the group turned off
);

    ldi_pkg::ldi_mon_state_t stateQ; // Registered state
    ldi_pkg::ldi_mon_state_t stateD; // Next state
    logic [`LDI_SINKS-1:0] wasOnMember; // Members on in the previous cycle
    logic [`LDI_SINKS-1:0] isOnMember; // Members on now

    // Restrict on status to selected members only
    genvar i;
    generate
        for (i = 0; i < `LDI_SINKS; i++) begin : g_member
            assign wasOnMember[i] = stateQ.prevOn[i] & groupSel[i];
            assign isOnMember[i] = sinkOn[i] & groupSel[i];
        end
    endgenerate

    // Group goes from some member on to every member off
    assign groupOff = (|wasOnMember) & ~(|isOnMember);

    // Next state: remember the sink status
    always_comb begin
        stateD = stateQ;
        stateD.prevOn = sinkOn;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateQ.prevOn <= `LDI_RST_SINKS;
        end else begin
            stateQ <= stateD;
        end
    end

    default clocking cbMon @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Group fully turning off from a previously lit member gives a pulse
    group_off_a: assert property (((|($past(sinkOn) & groupSel)) && !(|(sinkOn & groupSel))) |-> groupOff)
        else $error("group turned off without pulse");
    // Sink 9 outside the group never triggers on its own
    sink9_excl_a: assert property ((!groupSel[`LDI_SINKS-1] && !(|($past(sinkOn[`LDI_SINKS-2:0]) & groupSel[`LDI_SINKS-2:0])))
        |-> !groupOff)
        else $error("excluded sink 9 raised group off");

endmodule

// ---- rtl/ldi_int_ctrl.sv ----
`timescale 1ns/1ps
`include "ldi_defs.svh"

// What this block does
// - Enable bit 6 gates sink-group-off flag
// - Enable bit 5 gates backlight-done flag
// - Backlight fade-out end sets interrupt flag
// - Short flag with bit 4 raises interrupt
// - Disabled enables still let fault flags set
// - Thermal flag with bit 3 raises interrupt
// - Overvoltage flag with bit 2 raises interrupt
// - Register 0x04 bit 0 selects sink 9
// - All group members off sets flag
// - Unselected sink 9 excluded from group
// - Flags clear only by writing one
// - Config set: clear drops line 50 us
// - Low select register holds sinks 8..1
module ldi_int_ctrl #(
    parameter logic [`LDI_CW-1:0] DROP_CYCLES = `LDI_CW'(`LDI_DROP_CYCLES) // Line drop length in cycles
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [`LDI_DW-1:0] regAddr, // Register address from serial engine
    input wire logic [`LDI_DW-1:0] regWrData, // Write data
    input wire logic regWrEn, // One-cycle write strobe
    input wire logic regRdEn, // One-cycle read strobe
    output logic [`LDI_DW-1:0] regRdData, // Registered read data
    input wire logic intCfg, // Interrupt configuration bit
    input wire logic [`LDI_SINKS-1:0] sinkOn, // Sink on status, bit 0 is sink 1
    input wire logic backlightFadeDone, // Pulse: backlight fade-out ended
    input wire logic shortEvt, // Pulse: short or overload detected
    input wire logic thermalEvt, // Pulse: thermal shutdown
    input wire logic overvoltageEvt, // Pulse: output overvoltage
    output logic hostIntN // Host interrupt, active low
);

    ldi_pkg::ldi_state_t stateQ; // Registered state
    ldi_pkg::ldi_state_t stateD; // Next state
    logic groupOff; // Sink group turned off
    logic [`LDI_DW-1:0] setBits; // Event set vector
    logic [`LDI_DW-1:0] clrBits; // Host clear vector
    logic pendNext; // Enabled flag pending after this cycle
    logic clearAttempt; // Host clears a flag that is set

    // Address match used by both write and read paths
    function automatic logic isReg(input logic [`LDI_DW-1:0] addr, input logic [`LDI_DW-1:0] target);
        isReg = (addr == target);
    endfunction

    // Group membership: sink 9 from the high register, 8..1 from the low
    ldi_sink_group_mon uMon (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sinkOn(sinkOn),
        .groupSel({stateQ.selHi[`LDI_BIT_SINK9], stateQ.selLo}),
        .groupOff(groupOff)
    );

    // Next-state logic
    always_comb begin
        stateD = stateQ;
        // Events set flags regardless of the enables
        setBits = 8'h00;
        setBits[`LDI_BIT_ISC] = groupOff;
        setBits[`LDI_BIT_BL] = backlightFadeDone;
        setBits[`LDI_BIT_SHORT] = shortEvt;
        setBits[`LDI_BIT_TSD] = thermalEvt;
        setBits[`LDI_BIT_OVP] = overvoltageEvt;
        // Write of one clears; zero leaves the flag alone
        clrBits = 8'h00;
        if (regWrEn && isReg(regAddr, `LDI_ADDR_STAT)) begin
            clrBits = regWrData & `LDI_MASK_STAT;
        end
        // Set wins over a clear in the same cycle
        stateD.intStat = (stateQ.intStat & ~clrBits) | setBits;
        // Plain register writes
        if (regWrEn && isReg(regAddr, `LDI_ADDR_EN)) begin
            stateD.intEn = regWrData & `LDI_MASK_EN;
        end
        if (regWrEn && isReg(regAddr, `LDI_ADDR_SEL_HI)) begin
            stateD.selHi = regWrData & `LDI_MASK_SEL_HI;
        end
        if (regWrEn && isReg(regAddr, `LDI_ADDR_SEL_LO)) begin
            stateD.selLo = regWrData & `LDI_MASK_SEL_LO;
        end
        // Enabled flags decide the line
        pendNext = |(stateD.intStat & stateD.intEn);
        clearAttempt = |(clrBits & stateQ.intStat);
        // Line mode sequencing
        unique case (stateQ.line)
            ldi_pkg::LINE_FOLLOW: begin
                // Clearing while others pend: release line briefly
                if (intCfg && clearAttempt && pendNext) begin
                    stateD.line = ldi_pkg::LINE_DROP;
                    stateD.dropCnt = DROP_CYCLES - `LDI_CW'(1);
                end
            end
            ldi_pkg::LINE_DROP: begin
                // Count down, then follow the flags again
                if (stateQ.dropCnt == `LDI_RST_CNT) begin
                    stateD.line = ldi_pkg::LINE_FOLLOW;
                end else begin
                    stateD.dropCnt = stateQ.dropCnt - `LDI_CW'(1);
                end
            end
        endcase
        // Line low while an enabled flag pends, high during a drop
        stateD.intN = (stateD.line == ldi_pkg::LINE_DROP) | ~pendNext;
        // Read path; reading has no side effect on flags
        if (regRdEn) begin
            if (isReg(regAddr, `LDI_ADDR_STAT)) begin
                stateD.rdData = stateQ.intStat;
            end else if (isReg(regAddr, `LDI_ADDR_EN)) begin
                stateD.rdData = stateQ.intEn;
            end else if (isReg(regAddr, `LDI_ADDR_SEL_HI)) begin
                stateD.rdData = stateQ.selHi;
            end else if (isReg(regAddr, `LDI_ADDR_SEL_LO)) begin
                stateD.rdData = stateQ.selLo;
            end else begin
                stateD.rdData = `LDI_RST_RDATA; // Unmapped reads zero
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stateQ.intStat <= `LDI_RST_STAT;
            stateQ.intEn <= `LDI_RST_EN;
            stateQ.selHi <= `LDI_RST_SEL_HI;
            stateQ.selLo <= `LDI_RST_SEL_LO;
            stateQ.rdData <= `LDI_RST_RDATA;
            stateQ.line <= ldi_pkg::LINE_FOLLOW;
            stateQ.dropCnt <= `LDI_RST_CNT;
            stateQ.intN <= 1'b1;
        end else begin
            stateQ <= stateD;
        end
    end

    // Outputs straight from flops
    assign regRdData = stateQ.rdData;
    assign hostIntN = stateQ.intN;

    default clocking cbCtl @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Host write to the status register with a given bit set
    sequence statWrite(int b);
        regWrEn && regAddr == `LDI_ADDR_STAT && regWrData[b];
    endsequence
    // Clear attempt with other enabled flags still pending afterwards
    sequence clearWhilePending;
        regWrEn && regAddr == `LDI_ADDR_STAT && stateQ.line == ldi_pkg::LINE_FOLLOW
            && (|(regWrData & stateQ.intStat & `LDI_MASK_STAT))
            && (|(stateQ.intStat & ~regWrData & stateQ.intEn));
    endsequence

    sink_off_gate_a: assert property ((stateQ.intStat[`LDI_BIT_ISC] && stateQ.intEn[`LDI_BIT_ISC]
        && stateQ.line == ldi_pkg::LINE_FOLLOW) |-> !hostIntN)
        else $error("enabled sink group flag not on line");
    bl_gate_a: assert property ((stateQ.intStat[`LDI_BIT_BL] && stateQ.intEn[`LDI_BIT_BL]
        && stateQ.line == ldi_pkg::LINE_FOLLOW) |-> !hostIntN)
        else $error("enabled backlight flag not on line");
    bl_done_set_a: assert property (backlightFadeDone |=> stateQ.intStat[`LDI_BIT_BL])
        else $error("backlight fade end did not set flag");
    short_int_a: assert property ((shortEvt && stateQ.intEn[`LDI_BIT_SHORT] && !regWrEn && !intCfg)
        |=> !hostIntN)
        else $error("short event did not raise interrupt");
    fault_flag_set_a: assert property ((shortEvt && !stateQ.intEn[`LDI_BIT_SHORT])
        |=> stateQ.intStat[`LDI_BIT_SHORT] && $stable(stateQ.intEn))
        else $error("disabled short still must set flag");
    thermal_int_a: assert property ((thermalEvt && stateQ.intEn[`LDI_BIT_TSD] && !intCfg)
        |=> stateQ.intStat[`LDI_BIT_TSD] && !hostIntN)
        else $error("thermal event did not raise interrupt");
    overvoltage_flag_a: assert property ((overvoltageEvt && stateQ.intEn[`LDI_BIT_OVP] && !intCfg)
        |=> stateQ.intStat[`LDI_BIT_OVP] && !hostIntN)
        else $error("overvoltage event did not raise interrupt");
    sel_hi_write_a: assert property ((regWrEn && regAddr == `LDI_ADDR_SEL_HI)
        |=> stateQ.selHi == ($past(regWrData) & `LDI_MASK_SEL_HI))
        else $error("high select register wrong after write");
    w1c_clear_a: assert property ((statWrite(`LDI_BIT_OVP) ##0 !overvoltageEvt)
        |=> !stateQ.intStat[`LDI_BIT_OVP])
        else $error("write one did not clear flag");
    w0_keep_a: assert property ((stateQ.intStat[`LDI_BIT_TSD] && !(regWrEn && regAddr == `LDI_ADDR_STAT
        && regWrData[`LDI_BIT_TSD])) |=> stateQ.intStat[`LDI_BIT_TSD])
        else $error("flag lost without a write of one");
    drop_start_a: assert property ((clearWhilePending ##0 intCfg)
        |=> stateQ.line == ldi_pkg::LINE_DROP && hostIntN && stateQ.dropCnt == DROP_CYCLES - `LDI_CW'(1))
        else $error("line drop did not start");
    drop_end_a: assert property ((stateQ.line == ldi_pkg::LINE_DROP && stateQ.dropCnt == `LDI_RST_CNT)
        |=> stateQ.line == ldi_pkg::LINE_FOLLOW)
        else $error("line drop overran");
    no_drop_a: assert property ((clearWhilePending ##0 !intCfg) |=> !hostIntN)
        else $error("line released without configuration");
    sel_lo_write_a: assert property ((regWrEn && regAddr == `LDI_ADDR_SEL_LO)
        |=> stateQ.selLo == $past(regWrData))
        else $error("low select register wrong after write");
    idle_line_a: assert property (!(|(stateQ.intStat & stateQ.intEn)) |-> hostIntN)
        else $error("line asserted with nothing pending");

endmodule

// ---- verif/ldi_host_model.sv ----
`timescale 1ns/1ps
`include "ldi_defs.svh"

// Host side: register accesses as the serial engine hands them over
module ldi_host_model (
    input wire logic clk_sys, // System clock
    output logic [`LDI_DW-1:0] regAddr, // Register address
    output logic [`LDI_DW-1:0] regWrData, // Write data
    output logic regWrEn, // Write strobe
    output logic regRdEn // Read strobe
);
    // Idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    // Strobes drop; address and data are scrambled so stale values are never relied on
    task automatic release_bus();
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = ~regAddr;
        regWrData = ~regWrData;
    endtask

    // One write strobe held across one rising edge, after optional idle cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int idle = 0);
        repeat (idle) @(negedge clk_sys);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        release_bus();
    endtask

    // One read strobe
    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        release_bus();
    endtask

    // Clear flags: ones clear, zeros leave flags alone
    task automatic clr(input logic [7:0] m);
        wr(`LDI_ADDR_STAT, m);
    endtask
endmodule

// ---- verif/tb_ldi_int_ctrl.sv ----
`timescale 1ns/1ps
`include "ldi_defs.svh"

// Bench for the interrupt enable and sink group logic
module tb_ldi_int_ctrl;
    localparam int DROP = 8; // Shortened line drop
    logic clk_sys = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, active low
    logic [7:0] regAddr; // Address from host
    logic [7:0] regWrData; // Write data from host
    logic regWrEn; // Write strobe
    logic regRdEn; // Read strobe
    logic [7:0] regRdData; // Read data
    logic intCfg = 1'b0; // Line drop mode
    logic [8:0] sinkOn; // Sink states
    logic [3:0] evt; // Overvoltage, thermal, short, backlight
    logic hostIntN; // Interrupt line
    logic rdPend = 1'b0; // Read taken last edge
    logic [7:0] expQ[$]; // Expected read data
    logic [7:0] rnd = 8'h17; // Random state
    int n_mismatch = 0;
    int total_checks = 0;
    int cnt;

    // Clock
    always #5 clk_sys = ~clk_sys;

    ldi_host_model i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn));

    ldi_int_ctrl #(.DROP_CYCLES(13'h0008)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .intCfg(intCfg), .sinkOn(sinkOn), .backlightFadeDone(evt[3]),
        .shortEvt(evt[2]), .thermalEvt(evt[1]), .overvoltageEvt(evt[0]), .hostIntN(hostIntN));

    // Next random value
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Compare read data
    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compare the interrupt line
    task automatic check_int(input logic got, input logic exp);
        check_rd({7'h00, got}, {7'h00, exp});
    endtask

    // Read monitor: oldest note against each answer
    always @(posedge clk_sys) rdPend <= regRdEn;
    always @(negedge clk_sys) begin
        if (rdPend) begin
            check_rd(regRdData, expQ.pop_front());
        end
    end

    // Note the expected value, then read
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_host.rd(a);
    endtask

    // One-cycle event pulse
    task automatic pulse(input int i);
        @(negedge clk_sys);
        evt = 4'h1 << i;
        @(negedge clk_sys);
        evt = 4'h0;
    endtask

    // New sink states, then one edge for the monitor
    task automatic sinks(input logic [8:0] v);
        @(negedge clk_sys);
        sinkOn = v;
        @(negedge clk_sys);
    endtask

    // Counts and verdict
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        sinkOn = 9'h000;
        evt = 4'h0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        check_int(hostIntN, 1'b1);
        // Reset values; 0x06 and 0x07 are unmapped
        i_host.wr(8'h07, 8'hFF);
        for (int a = 2; a < 8; a++) rd_chk(8'(a), 8'h00);
        // Reserved bits ignored on write
        i_host.wr(`LDI_ADDR_EN, 8'hFF);
        rd_chk(`LDI_ADDR_EN, `LDI_MASK_EN);
        i_host.wr(`LDI_ADDR_SEL_HI, 8'hFE, 2);
        rd_chk(`LDI_ADDR_SEL_HI, 8'h00);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            i_host.wr(`LDI_ADDR_SEL_LO, rnd);
            rd_chk(`LDI_ADDR_SEL_LO, rnd);
        end
        i_host.wr(`LDI_ADDR_EN, 8'h00);
        // Each event: disabled, enabled, zero write, one write
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            check_int(hostIntN, 1'b1);
            i_host.wr(`LDI_ADDR_EN, 8'(1 << (i + 2)));
            @(negedge clk_sys);
            check_int(hostIntN, 1'b0);
            i_host.clr(8'h00);
            rd_chk(`LDI_ADDR_STAT, 8'(1 << (i + 2)));
            i_host.clr(8'(1 << (i + 2)));
            @(negedge clk_sys);
            check_int(hostIntN, 1'b1);
            rd_chk(`LDI_ADDR_STAT, 8'h00);
            // Event while already enabled raises the line at once
            pulse(i);
            check_int(hostIntN, 1'b0);
            i_host.clr(8'(1 << (i + 2)));
        end
        // Group of sinks 1 and 2, sink 9 left out
        i_host.wr(`LDI_ADDR_EN, 8'h40);
        i_host.wr(`LDI_ADDR_SEL_LO, 8'h03);
        i_host.wr(`LDI_ADDR_SEL_HI, 8'h00);
        sinks(9'h103);
        sinks(9'h100);
        check_int(hostIntN, 1'b0);
        i_host.clr(8'h40);
        // Sink 9 joins: group off only once sink 9 is off too
        i_host.wr(`LDI_ADDR_SEL_HI, 8'h01);
        sinks(9'h103);
        sinks(9'h100);
        check_int(hostIntN, 1'b1);
        sinks(9'h000);
        check_int(hostIntN, 1'b0);
        i_host.clr(8'h40);
        // Indicator disabled keeps the line quiet
        i_host.wr(`LDI_ADDR_EN, 8'h00);
        sinks(9'h100);
        sinks(9'h000);
        check_int(hostIntN, 1'b1);
        i_host.clr(8'h40);
        // Line drop while another event stays pending
        i_host.wr(`LDI_ADDR_EN, 8'h7C);
        @(negedge clk_sys);
        intCfg = 1'b1;
        pulse(2);
        pulse(1);
        i_host.clr(8'h10);
        cnt = 0;
        while (hostIntN === 1'b1 && cnt < 4 * DROP) begin
            cnt++;
            @(negedge clk_sys);
        end
        if (cnt == 4 * DROP) begin
            n_mismatch++;
        end
        check_rd(8'(cnt), 8'(DROP));
        // Without the mode bit the line stays low
        @(negedge clk_sys);
        intCfg = 1'b0;
        pulse(2);
        i_host.clr(8'h08);
        check_int(hostIntN, 1'b0);
        finish_test();
    end
endmodule
